// *** dv/rdt_sensor_model.sv ***
// Purpose: Behavioural model of five capacitor discharge sensor circuits.
// Assumes: Hold times are given in system clocks per line.
// Notes: A released line that was never charged reads low.
`timescale 1ns/100ps
`default_nettype none
module rdt_sensor_model #(
    parameter int NS = 5
) (
    input  wire logic             i_mclk,
    input  wire logic [NS-1:0]    i_line_out,
    input  wire logic [NS-1:0]    i_line_oe_n,
    input  wire logic [NS*16-1:0] i_hold_cyc,
    output var  logic [NS-1:0]    o_pin
);
    int            age [NS];
    logic [NS-1:0] charged = '0;
    initial for (int i = 0; i < NS; i++) age[i] = 0;
    always @(posedge i_mclk) begin
        for (int i = 0; i < NS; i++) begin
            if (!i_line_oe_n[i]) begin
                age[i] <= 0;
                charged[i] <= i_line_out[i];
            end else begin
                age[i] <= age[i] + 1;
            end
        end
    end
    // The line stays high only until its stored charge has drained.
    always_comb begin
        for (int i = 0; i < NS; i++) begin
            o_pin[i] = !i_line_oe_n[i] ? i_line_out[i]
                     : (charged[i] && age[i] < int'(i_hold_cyc[i*16+:16]));
        end
    end
endmodule : rdt_sensor_model
`default_nettype wire

// *** dv/reflectance_discharge_timer_tb_top.sv ***
// Purpose: Self-checking bench for the discharge timer readout.
// Assumes: Shortened charge time and limit keep the run brief.
// Notes: Tick phase is free running, so timed results allow two ticks.
`timescale 1ns/100ps
`default_nettype none
module reflectance_discharge_timer_tb_top;
    localparam int NS  = rdt_pkg::NUM_SENSORS;
    localparam int RW  = rdt_pkg::RES_W;
    localparam int LIM = 40;
    localparam int CHG = 10;
    logic             i_mclk     = 1'b0;
    logic             i_nrst     = 1'b0;
    logic             i_start    = 1'b0;
    logic             i_button_n = 1'b1;
    logic             busy, done, button_level;
    logic [NS-1:0]    pin, line_out, line_oe_n;
    logic [NS*RW-1:0] result;
    logic [NS*16-1:0] hold = '0;
    logic [31:0]      seed = 32'hACDA;
    logic             btn_q [$];
    int               errors = 0;
    int               compares = 0;
    int               n, h, e;

    rdt_readout #(.NS(NS), .TIME_LIMIT(RW'(LIM)), .CHARGE_CYC(CHG)) dut (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_start(i_start), .o_busy(busy), .o_done(done),
        .i_sensor_line(pin), .o_sensor_line_out(line_out), .o_sensor_line_oe_n(line_oe_n),
        .i_button_n(i_button_n), .o_button_level(button_level), .o_result(result));
    rdt_sensor_model #(.NS(NS)) model (.i_mclk(i_mclk),
        .i_line_out(line_out), .i_line_oe_n(line_oe_n), .i_hold_cyc(hold), .o_pin(pin));

    initial forever #50 i_mclk = ~i_mclk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
        logic ok;
        ok = 1'b0;
        for (int d = -tol; d <= tol; d++) if (got === exp + 32'(d)) ok = 1'b1;
        compares++;
        if (!ok) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    // Released button reads high, pressed reads low, three clocks late.
    initial begin
        wait (i_nrst === 1'b1);
        forever begin
            @(negedge i_mclk);
            if (btn_q.size() >= 3) chk(32'(button_level), 32'(btn_q[2]), 0);
            i_button_n = 1'(xs() % 2);
            btn_q.push_front(i_button_n);
            if (btn_q.size() > 3) void'(btn_q.pop_back());
        end
    end

    initial begin
        repeat (20000) @(posedge i_mclk);
        errors++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge i_mclk);
        @(negedge i_mclk);
        i_nrst = 1'b1;
        // Start is held high so passes run back to back.
        for (int p = 0; p < 8; p++) begin
            @(negedge i_mclk);
            for (int i = 0; i < NS; i++) begin
                h = (p == 0) ? 0 : (p == 1) ? 4 * LIM + 40 : int'(xs() % (4 * LIM + 40));
                hold[i*16+:16] = 16'(h);
            end
            i_start = 1'b1;
            n = 0;
            while (busy !== 1'b1 && n < 10) begin
                @(negedge i_mclk);
                n++;
            end
            chk(32'(line_oe_n), 32'h0, 0);
            chk(32'(line_out), 32'h1F, 0);
            n = 0;
            while (done !== 1'b1 && n < 1000) begin
                @(negedge i_mclk);
                n++;
            end
            chk(32'(n), 32'(CHG + 4 * LIM + 2), 6);
            chk(32'(busy), 32'h0, 0);
            for (int i = 0; i < NS; i++) begin
                h = int'(hold[i*16+:16]);
                e = (h + 2) / 4 < LIM ? (h + 2) / 4 : LIM;
                chk(32'(result[i*RW+:RW]), 32'(e), h >= 4 * LIM + 12 ? 0 : 2);
            end
            @(negedge i_mclk);
            chk(32'(done), 32'h0, 0);
        end
        test_done();
    end
endmodule : reflectance_discharge_timer_tb_top
`default_nettype wire

// *** hw/rdt_pkg.sv ***
// Purpose: Shared constants for the reflectance discharge timer.
// Assumes: 10 MHz system clock, five sensor lines, one pushbutton.
// Notes: None.
package rdt_pkg;
    localparam int CLK_NS       = 100;
    localparam int TICK_NS      = 400;
    localparam int TICK_CYC     = TICK_NS / CLK_NS;
    localparam int CHARGE_US    = 10;
    localparam int CHARGE_CYC   = (CHARGE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int NUM_SENSORS  = 5;
    localparam int LIMIT_TICKS  = 2000;
    localparam int RES_W        = 12;
    localparam int TICK_W       = 8;
    localparam int PRE_W        = 3;
    localparam int CHG_W        = 8;
    localparam int SYNC_STAGES  = 2;
    localparam logic [PRE_W-1:0]  PRE_RESET  = 3'h0;
    localparam logic [TICK_W-1:0] TICK_RESET = 8'h00;
    localparam logic [TICK_W-1:0] TICK_STEP  = 8'h01;

    typedef enum logic [1:0] {ST_IDLE, ST_CHARGE, ST_MEASURE, ST_DONE} rdt_state_type;
endpackage : rdt_pkg

// *** hw/rdt_readout.sv ***
// Purpose: Charges five reflectance sensor lines, times their discharge.
// Assumes: Sensor and button pins are asynchronous to i_mclk.
// Notes: Bit 0 of the sensor group is the leftmost sensor line.
`timescale 1ns/100ps
`default_nettype none
module rdt_readout #(
    parameter int                      NS         = rdt_pkg::NUM_SENSORS,
    parameter logic [rdt_pkg::RES_W-1:0] TIME_LIMIT = rdt_pkg::RES_W'(rdt_pkg::LIMIT_TICKS),
    parameter int                      CHARGE_CYC = rdt_pkg::CHARGE_CYC
) (
    // Clock and reset.
    input  wire logic                       i_mclk,
    input  wire logic                       i_nrst,
    // Control.
    input  wire logic                       i_start,
    output logic                            o_busy,
    output logic                            o_done,
    // Sensor lines, split into input, output and enable.
    input  wire logic [NS-1:0]              i_sensor_line,
    output logic      [NS-1:0]              o_sensor_line_out,
    output logic      [NS-1:0]              o_sensor_line_oe_n,
    // Pushbutton, pulled up outside.
    input  wire logic                       i_button_n,
    output logic                            o_button_level,
    // Results, sensor i in bits i*RES_W upward.
    output logic [NS*rdt_pkg::RES_W-1:0]    o_result
);
    localparam int W = rdt_pkg::RES_W;

    if (NS < 1 || int'(TIME_LIMIT) + 255 >= (1 << W) ||
        CHARGE_CYC < 1 || CHARGE_CYC > (1 << rdt_pkg::CHG_W)) begin : g_bad_cfg
        $error("Readout parameters out of range.");
    end

    rdt_tick_if tick ();

    rdt_tick_gen #(.TICK_CYC(rdt_pkg::TICK_CYC)) u_tick (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .tick   (tick.src)
    );

    // Two-stage synchronisers; only stage two is read by logic.
    logic [NS-1:0] sens_s1_q, sens_s2_q;
    logic          btn_s1_q,  btn_s2_q;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sens_s1_q <= '0;
            sens_s2_q <= '0;
            btn_s1_q  <= 1'b1;
            btn_s2_q  <= 1'b1;
        end else begin
            sens_s1_q <= i_sensor_line;
            sens_s2_q <= sens_s1_q;
            btn_s1_q  <= i_button_n;
            btn_s2_q  <= btn_s1_q;
        end
    end

    rdt_pkg::rdt_state_type     state_q,     state_d;
    logic [rdt_pkg::CHG_W-1:0]  charge_q,    charge_d;
    logic [W-1:0]               elapsed_q,   elapsed_d;
    logic [rdt_pkg::TICK_W-1:0] last_tick_q, last_tick_d;
    logic [rdt_pkg::TICK_W-1:0] delta;
    logic [NS-1:0]              sample_q,    sample_d;
    logic [NS*W-1:0]            result_q,    result_d;
    logic [NS-1:0]              drive_q,     drive_d;
    logic [NS-1:0]              oe_n_q,      oe_n_d;
    logic                       busy_q,      busy_d;
    logic                       done_q,      done_d;
    logic                       btn_q,       btn_d;

    always_comb begin
        state_d     = state_q;
        charge_d    = charge_q;
        elapsed_d   = elapsed_q;
        last_tick_d = last_tick_q;
        sample_d    = sample_q;
        result_d    = result_q;
        // Modular difference stays correct across counter wrap.
        delta       = tick.count - last_tick_q;
        btn_d       = btn_s2_q;
        case (state_q)
            rdt_pkg::ST_IDLE: begin
                if (i_start) begin
                    state_d  = rdt_pkg::ST_CHARGE;
                    charge_d = '0;
                end
            end
            rdt_pkg::ST_CHARGE: begin
                charge_d = charge_q + 8'h01;
                if (charge_q == rdt_pkg::CHG_W'(CHARGE_CYC - 1)) begin
                    state_d     = rdt_pkg::ST_MEASURE;
                    elapsed_d   = '0;
                    last_tick_d = tick.count;
                    sample_d    = '1;
                    // Lines that never fall keep the limit value.
                    result_d    = {NS{TIME_LIMIT}};
                end
            end
            rdt_pkg::ST_MEASURE: begin
                elapsed_d   = elapsed_q + W'(delta);
                last_tick_d = last_tick_q + delta;
                if (sens_s2_q != sample_q) begin
                    sample_d = sens_s2_q;
                    for (int i = 0; i < NS; i++) begin
                        if (sample_q[i] && !sens_s2_q[i]) begin
                            result_d[i*W +: W] = elapsed_q;
                        end
                    end
                end
                if (elapsed_d >= TIME_LIMIT) begin
                    state_d = rdt_pkg::ST_DONE;
                end
            end
            rdt_pkg::ST_DONE: begin
                state_d = rdt_pkg::ST_IDLE;
            end
            default: begin
                state_d = rdt_pkg::ST_IDLE;
            end
        endcase
        // Outputs are decoded from the next state so they stay registered.
        drive_d = (state_d == rdt_pkg::ST_CHARGE) ? '1 : '0;
        oe_n_d  = (state_d == rdt_pkg::ST_CHARGE) ? '0 : '1;
        busy_d  = (state_d == rdt_pkg::ST_CHARGE) || (state_d == rdt_pkg::ST_MEASURE);
        done_d  = (state_d == rdt_pkg::ST_DONE);
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q     <= rdt_pkg::ST_IDLE;
            charge_q    <= '0;
            elapsed_q   <= '0;
            last_tick_q <= rdt_pkg::TICK_RESET;
            sample_q    <= '0;
            result_q    <= '0;
            drive_q     <= '0;
            oe_n_q      <= '1;
            busy_q      <= 1'b0;
            done_q      <= 1'b0;
            btn_q       <= 1'b1;
        end else begin
            state_q     <= state_d;
            charge_q    <= charge_d;
            elapsed_q   <= elapsed_d;
            last_tick_q <= last_tick_d;
            sample_q    <= sample_d;
            result_q    <= result_d;
            drive_q     <= drive_d;
            oe_n_q      <= oe_n_d;
            busy_q      <= busy_d;
            done_q      <= done_d;
            btn_q       <= btn_d;
        end
    end

    assign o_sensor_line_out  = drive_q;
    assign o_sensor_line_oe_n = oe_n_q;
    assign o_busy             = busy_q;
    assign o_done             = done_q;
    assign o_result           = result_q;
    assign o_button_level     = btn_q;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    a_button_follow: assert property (
        (i_button_n == $past(i_button_n))[*4] |-> o_button_level == i_button_n)
        else $error("Button level does not follow the pin.");

    a_charge_drive: assert property (
        state_q == rdt_pkg::ST_CHARGE |-> o_sensor_line_oe_n == '0 && o_sensor_line_out == '1)
        else $error("Lines not driven high while charging.");

    a_measure_release: assert property (
        state_q == rdt_pkg::ST_MEASURE |-> o_sensor_line_oe_n == '1)
        else $error("Lines still driven while measuring.");

    a_tick_period: assert property (
        tick.count != $past(tick.count) |=> (tick.count == $past(tick.count))[*3]
        ##1 tick.count == $past(tick.count) + rdt_pkg::TICK_STEP)
        else $error("Tick counter period wrong.");

    a_elapsed_grows: assert property (
        state_q == rdt_pkg::ST_MEASURE |=>
        elapsed_q == $past(elapsed_q) + W'($past(tick.count) != $past(tick.count, 2)) ||
        state_q == rdt_pkg::ST_DONE)
        else $error("Elapsed time does not track ticks.");

    a_no_change: assert property (
        state_q == rdt_pkg::ST_MEASURE && sens_s2_q == sample_q |=> $stable(o_result))
        else $error("Results changed without a port change.");

    a_fall_store: assert property (
        state_q == rdt_pkg::ST_MEASURE && sample_q[0] && !sens_s2_q[0]
        |=> o_result[W-1:0] == $past(elapsed_q))
        else $error("Leftmost fall time not stored.");

    a_limit_end: assert property (
        state_q == rdt_pkg::ST_MEASURE && elapsed_d >= TIME_LIMIT |=> o_done ##1 !o_done)
        else $error("Pass did not end at the limit.");

    a_result_range: assert property (
        o_done |-> o_result[W-1:0] <= TIME_LIMIT && o_result[NS*W-1 -: W] <= TIME_LIMIT)
        else $error("Result beyond the limit.");

    c_pass_done:   cover property (state_q == rdt_pkg::ST_MEASURE ##1 o_done);
    c_fall_seen:   cover property (state_q == rdt_pkg::ST_MEASURE && sample_q[0] && !sens_s2_q[0]);
    c_timeout:     cover property (o_done && o_result[W-1:0] == TIME_LIMIT);
    c_button_push: cover property (o_button_level ##1 !o_button_level);
endmodule : rdt_readout
`default_nettype wire

// *** hw/rdt_tick_gen.sv ***
// Purpose: Free-running tick counter advancing once per tick period.
// Assumes: TICK_CYC clock cycles per tick.
// Notes: Wraps to zero; the reader accumulates differences.
`timescale 1ns/100ps
`default_nettype none
module rdt_tick_gen #(
    parameter int TICK_CYC = rdt_pkg::TICK_CYC
) (
    // Clock and reset.
    input  wire logic  i_mclk,
    input  wire logic  i_nrst,
    // Tick value.
    rdt_tick_if.src    tick
);
    logic [rdt_pkg::PRE_W-1:0]  pre_q,  pre_d;
    logic [rdt_pkg::TICK_W-1:0] cnt_q,  cnt_d;

    if (TICK_CYC < 1 || TICK_CYC > (1 << rdt_pkg::PRE_W)) begin : g_bad_tick
        $error("Tick divider does not fit the prescaler.");
    end

    always_comb begin
        pre_d = pre_q + 3'h1;
        cnt_d = cnt_q;
        if (pre_q == rdt_pkg::PRE_W'(TICK_CYC - 1)) begin
            pre_d = rdt_pkg::PRE_RESET;
            cnt_d = cnt_q + rdt_pkg::TICK_STEP;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_q <= rdt_pkg::PRE_RESET;
            cnt_q <= rdt_pkg::TICK_RESET;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    assign tick.count = cnt_q;
endmodule : rdt_tick_gen
`default_nettype wire

// *** hw/rdt_tick_if.sv ***
// Purpose: Carries the tick counter value from its source to the readout.
// Assumes: Single clock domain.
// Notes: None.
`timescale 1ns/100ps
`default_nettype none
interface rdt_tick_if;
    logic [rdt_pkg::TICK_W-1:0] count;
    modport src (output count);
    modport snk (input count);
endinterface : rdt_tick_if
`default_nettype wire
